// ---- src/async_tx_regs.vh ----
// Register offsets, field positions, reset values and timing constants
// for the asynchronous serial transmitter. Definitions only.
`ifndef ASYNC_TX_REGS_VH
`define ASYNC_TX_REGS_VH

// Register byte offsets on the APB window
`define OFS_SERIAL_DATA_REG   12'h000
`define OFS_SERIAL_STATUS_REG 12'h004
`define OFS_TX_CTRL           12'h008
`define OFS_TX_BAUD           12'h00C
`define OFS_RX_BAUD           12'h010
`define OFS_IRQ_STATUS        12'h014
`define OFS_IRQ_CLEAR         12'h018
`define OFS_IRQ_ENABLE        12'h01C

// Control register fields
`define CTRL_TX_GO            0
`define CTRL_RX_GO            1
`define CTRL_SEND_BREAK       2
`define CTRL_NINE_BIT         3
`define CTRL_TX_NINTH_BIT     4
`define CTRL_EMPTY_IRQ_EN     5
`define CTRL_DONE_IRQ_EN      6
`define CTRL_WIDTH            7
`define CTRL_RESET            7'h00

// Serial status register fields
`define STAT_TX_EMPTY         7
`define STAT_TX_DONE          6

// Sticky event bits of the interrupt status register
`define EVT_TX_EMPTY          0
`define EVT_TX_DONE           1
`define EVT_WIDTH             2
`define EVT_RESET             2'h0

// Baud divisor: CPU clocks per bit time minus one, 16 bits
`define BAUD_WIDTH            16
`define BAUD_RESET            16'h0032

// Clock and fastest bit rate
`define CLK_HZ                25000000
`define MAX_BAUD              500000
`define MIN_BIT_CYCLES        (`CLK_HZ / `MAX_BAUD)

`endif

// ---- src/async_serial_transmitter.v ----
// Transmit half of an asynchronous NRZ serial interface behind APB.
// Assumes a single 25 MHz clock, synchronous active-high reset, a
// standard APB master and a global interrupt mask input from the CPU.
`timescale 1ns/1ps
`default_nettype none
`include "async_tx_regs.vh"

module async_serial_transmitter (
  input  wire        clk_sys_i,     // System clock, 25 MHz
  input  wire        srst_i,        // Synchronous reset, active high
  input  wire        psel_i,        // APB select
  input  wire        penable_i,     // APB access phase
  input  wire        pwrite_i,      // APB direction, high for write
  input  wire [11:0] paddr_i,       // APB byte address
  input  wire [31:0] pwdata_i,      // APB write data
  output wire        pready_o,      // APB ready, always high
  output reg  [31:0] prdata_o,      // APB read data
  output wire        pslverr_o,     // APB error on unmapped address
  input  wire        irq_mask_i,    // CPU global interrupt mask
  output wire        serial_tx_o,   // Serial data out
  output wire        serial_tx_oe_o,// High while serial function owns pin
  output wire        rx_baud_tick_o,// Receive bit tick for receiver
  output wire        irq_o          // Level interrupt
);

  // Transmit sequencer states
  localparam [1:0] ST_IDLE  = 2'b00;
  localparam [1:0] ST_FRAME = 2'b01;
  localparam [1:0] ST_MARK  = 2'b10;

  // Frame kinds
  localparam [1:0] K_DATA  = 2'b00;
  localparam [1:0] K_IDLE  = 2'b01;
  localparam [1:0] K_BREAK = 2'b10;

  reg  [`CTRL_WIDTH-1:0] ctrl;
  reg  [`BAUD_WIDTH-1:0] tx_baud;
  reg  [`BAUD_WIDTH-1:0] rx_baud;
  reg  [`BAUD_WIDTH-1:0] tx_cnt;
  reg  [`BAUD_WIDTH-1:0] rx_cnt;
  reg  [`EVT_WIDTH-1:0]  evt_status;
  reg  [`EVT_WIDTH-1:0]  evt_enable;
  reg  [8:0]             tx_holding_buffer;
  reg                    hold_full;
  reg                    tx_buffer_empty_flag;
  reg                    tx_done_flag;
  reg                    status_seen;
  reg                    idle_pending;
  reg                    tx_go_d;
  reg  [1:0]             state;
  reg  [1:0]             kind;
  reg  [10:0]            shifter;
  reg  [3:0]             bits_left;
  reg                    line;

  wire tx_go     = ctrl[`CTRL_TX_GO];
  wire rx_go     = ctrl[`CTRL_RX_GO];
  wire send_break = ctrl[`CTRL_SEND_BREAK];
  wire nine_bit  = ctrl[`CTRL_NINE_BIT];

  // APB decode; zero wait states
  wire acc      = psel_i & penable_i;
  wire wr       = acc & pwrite_i;
  wire rd       = acc & ~pwrite_i;
  wire a_data   = (paddr_i == `OFS_SERIAL_DATA_REG);
  wire a_stat   = (paddr_i == `OFS_SERIAL_STATUS_REG);
  wire a_ctrl   = (paddr_i == `OFS_TX_CTRL);
  wire a_tbaud  = (paddr_i == `OFS_TX_BAUD);
  wire a_rbaud  = (paddr_i == `OFS_RX_BAUD);
  wire a_ist    = (paddr_i == `OFS_IRQ_STATUS);
  wire a_iclr   = (paddr_i == `OFS_IRQ_CLEAR);
  wire a_ien    = (paddr_i == `OFS_IRQ_ENABLE);
  wire mapped   = a_data | a_stat | a_ctrl | a_tbaud | a_rbaud |
                  a_ist | a_iclr | a_ien;
  assign pready_o  = 1'b1;
  assign pslverr_o = acc & ~mapped;

  wire data_wr    = wr & a_data;
  // Flag clear needs a prior status read; unread writes still load data
  wire seq_clear  = data_wr & status_seen;

  // Bit timer; divisor of zero gives one-clock bits
  wire tx_tick = (tx_cnt == {`BAUD_WIDTH{1'b0}});
  wire rx_tick = (rx_cnt == {`BAUD_WIDTH{1'b0}});
  assign rx_baud_tick_o = rx_tick & rx_go;

  // Independent transmit and receive bit timers
  always @(posedge clk_sys_i) begin
    if (srst_i) begin
      tx_cnt <= {`BAUD_WIDTH{1'b0}};
      rx_cnt <= {`BAUD_WIDTH{1'b0}};
    end else begin
      // Reload with the divisor itself: a bit lasts divisor+1 clocks
      if (tx_tick || state == ST_IDLE)
        tx_cnt <= tx_baud;
      else
        tx_cnt <= tx_cnt - 1'b1;
      if (rx_tick || !rx_go)
        rx_cnt <= rx_baud;
      else
        rx_cnt <= rx_cnt - 1'b1;
    end
  end

  // Frame ends on the tick that finishes the stop position
  wire frame_end = (state == ST_FRAME) && tx_tick && (bits_left == 4'h1);
  wire mark_end  = (state == ST_MARK) && tx_tick;
  wire tx_rise   = tx_go & ~tx_go_d;

  // Frame lengths: start + data + stop, 10 or 11 bit times
  wire [3:0] frame_bits = nine_bit ? 4'hB : 4'hA;

  // Data word with start bit at bit 0, stop bit at top, LSB first
  wire [8:0]  word_in   = nine_bit ? {ctrl[`CTRL_TX_NINTH_BIT],
                                      pwdata_i[7:0]}
                                   : {1'b1, pwdata_i[7:0]};
  wire [8:0]  hold_word = tx_holding_buffer;
  wire [10:0] data_frame_w = {1'b1, word_in, 1'b0};
  wire [10:0] data_frame_h = {1'b1, hold_word, 1'b0};

  // A direct write loads the shifter only when nothing is pending
  wire idle_free   = (state == ST_IDLE) && !idle_pending && !send_break;
  wire direct_load = data_wr && tx_go && idle_free && !hold_full;

  // Sequencer: idle frames, break frames, data frames, trailing mark
  always @(posedge clk_sys_i) begin
    if (srst_i) begin
      state        <= ST_IDLE;
      kind         <= K_DATA;
      shifter      <= 11'h7FF;
      bits_left    <= 4'h0;
      line         <= 1'b1;
      idle_pending <= 1'b0;
      tx_go_d      <= 1'b0;
      hold_full    <= 1'b0;
      tx_holding_buffer <= 9'h000;
    end else begin
      tx_go_d <= tx_go;
      // Idle frame queued on each rising tx_go
      if (tx_rise)
        idle_pending <= 1'b1;
      // Buffered write while busy waits in the holding buffer
      if (data_wr && tx_go && !direct_load) begin
        tx_holding_buffer <= word_in;
        hold_full         <= 1'b1;
      end
      if (!tx_go) begin
        // Dropping tx_go discards pending data
        state     <= ST_IDLE;
        line      <= 1'b1;
        hold_full <= 1'b0;
      end else begin
        case (state)
          ST_IDLE: begin
            line <= 1'b1;
            if (idle_pending) begin
              state        <= ST_FRAME;
              kind         <= K_IDLE;
              shifter      <= 11'h7FF;
              bits_left    <= frame_bits;
              idle_pending <= tx_rise;
              line         <= 1'b1;
            end else if (send_break) begin
              state     <= ST_FRAME;
              kind      <= K_BREAK;
              shifter   <= 11'h000;
              bits_left <= frame_bits;
              line      <= 1'b0;
            end else if (hold_full) begin
              state     <= ST_FRAME;
              kind      <= K_DATA;
              shifter   <= {1'b1, data_frame_h[10:1]};
              bits_left <= frame_bits;
              line      <= 1'b0;
              hold_full <= data_wr;
            end else if (direct_load) begin
              state     <= ST_FRAME;
              kind      <= K_DATA;
              shifter   <= {1'b1, data_frame_w[10:1]};
              bits_left <= frame_bits;
              line      <= 1'b0;
            end
          end
          ST_FRAME: begin
            if (tx_tick) begin
              bits_left <= bits_left - 4'h1;
              line      <= shifter[0];
              shifter   <= {1'b1, shifter[10:1]};
              if (bits_left == 4'h1) begin
                if (kind == K_BREAK && send_break) begin
                  shifter   <= 11'h7FF;
                  bits_left <= frame_bits;
                  line      <= 1'b0;
                end else if (kind == K_BREAK) begin
                  state <= ST_MARK;
                  line  <= 1'b1;
                end else begin
                  state <= ST_IDLE;
                  line  <= 1'b1;
                end
              end
            end
            if (kind == K_BREAK && bits_left != 4'h1)
              line <= 1'b0;
          end
          ST_MARK: begin
            line <= 1'b1;
            if (mark_end)
              state <= ST_IDLE;
          end
          default: begin
            state <= ST_IDLE;
            line  <= 1'b1;
          end
        endcase
      end
    end
  end

  // Shifter takes a new word: transfer beginning with buffer now empty
  wire start_data = tx_go && (state == ST_IDLE) && !idle_pending &&
                    !send_break && (hold_full || direct_load) &&
                    !(hold_full && data_wr);
  wire done_evt   = frame_end && !(kind == K_BREAK && send_break) &&
                    (kind != K_IDLE);
  wire break_done = frame_end && kind == K_BREAK && send_break;

  // Flags; a hardware set wins over a same-cycle software clear
  always @(posedge clk_sys_i) begin
    if (srst_i) begin
      tx_buffer_empty_flag <= 1'b1;
      tx_done_flag         <= 1'b1;
      status_seen          <= 1'b0;
    end else begin
      if (rd && a_stat)
        status_seen <= 1'b1;
      else if (data_wr)
        status_seen <= 1'b0;
      if (start_data)
        tx_buffer_empty_flag <= 1'b1;
      else if (seq_clear)
        tx_buffer_empty_flag <= 1'b0;
      if (done_evt || break_done)
        tx_done_flag <= 1'b1;
      else if (seq_clear)
        tx_done_flag <= 1'b0;
    end
  end

  // Sticky interrupt events, cleared by writing ones
  wire [`EVT_WIDTH-1:0] evt_set;
  assign evt_set[`EVT_TX_EMPTY] = start_data;
  assign evt_set[`EVT_TX_DONE]  = done_evt | break_done;

  // Configuration registers
  always @(posedge clk_sys_i) begin
    if (srst_i) begin
      ctrl       <= `CTRL_RESET;
      tx_baud    <= `BAUD_RESET;
      rx_baud    <= `BAUD_RESET;
      evt_status <= `EVT_RESET;
      evt_enable <= `EVT_RESET;
    end else begin
      if (wr && a_ctrl)
        ctrl <= pwdata_i[`CTRL_WIDTH-1:0];
      if (wr && a_tbaud)
        tx_baud <= pwdata_i[`BAUD_WIDTH-1:0];
      if (wr && a_rbaud)
        rx_baud <= pwdata_i[`BAUD_WIDTH-1:0];
      if (wr && a_ien)
        evt_enable <= pwdata_i[`EVT_WIDTH-1:0];
      evt_status <= evt_set |
                    (evt_status & ~((wr && a_iclr) ?
                     pwdata_i[`EVT_WIDTH-1:0] : `EVT_RESET));
    end
  end

  // Read data, registered on the setup cycle
  always @(posedge clk_sys_i) begin
    if (srst_i)
      prdata_o <= 32'h00000000;
    else if (psel_i && !penable_i && !pwrite_i) begin
      prdata_o <= 32'h00000000;
      if (a_stat) begin
        prdata_o[`STAT_TX_EMPTY] <= tx_buffer_empty_flag;
        prdata_o[`STAT_TX_DONE]  <= tx_done_flag;
      end
      if (a_ctrl)
        prdata_o[`CTRL_WIDTH-1:0] <= ctrl;
      if (a_tbaud)
        prdata_o[`BAUD_WIDTH-1:0] <= tx_baud;
      if (a_rbaud)
        prdata_o[`BAUD_WIDTH-1:0] <= rx_baud;
      if (a_ist)
        prdata_o[`EVT_WIDTH-1:0] <= evt_status;
      if (a_ien)
        prdata_o[`EVT_WIDTH-1:0] <= evt_enable;
    end
  end

  // Pin ownership: port logic regains pin when both directions are off
  assign serial_tx_oe_o = tx_go | rx_go;
  assign serial_tx_o    = tx_go ? line : 1'b1;

  // Interrupt: level flags and sticky events gated by enables and the CPU global mask
  wire flag_irq = (tx_buffer_empty_flag & ctrl[`CTRL_EMPTY_IRQ_EN]) |
                  (tx_done_flag & ctrl[`CTRL_DONE_IRQ_EN]);
  assign irq_o = ~irq_mask_i & (flag_irq | |(evt_status & evt_enable));

endmodule
`default_nettype wire

// ---- tb/async_tx_properties.sv ----
// Port checker for the serial transmitter.
// Assumes no reset in mid-frame and divisor writes only while idle.
`timescale 1ns/1ps
`default_nettype none
`include "async_tx_regs.vh"
module async_tx_properties (
  input wire logic        clk_sys_i,      // Clock
  input wire logic        srst_i,         // Reset
  input wire logic        psel_i,         // Select
  input wire logic        penable_i,      // Access
  input wire logic        pwrite_i,       // Write
  input wire logic [11:0] paddr_i,        // Address
  input wire logic [31:0] pwdata_i,       // Write data
  input wire logic        pready_o,       // Ready
  input wire logic        pslverr_o,      // Error
  input wire logic        irq_mask_i,     // Global mask
  input wire logic        serial_tx_o,    // Line
  input wire logic        serial_tx_oe_o, // Pin owned
  input wire logic        rx_baud_tick_o, // Rx tick
  input wire logic        irq_o           // Interrupt
);
  logic [6:0]  ctrl;
  logic [15:0] baud;
  int unsigned low_cnt;
  wire         wr = psel_i & penable_i & pwrite_i & pready_o;
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (srst_i);
  // Shadow of control and divisor, so checks need no internal probes
  always @(posedge clk_sys_i) begin
    if (srst_i) begin
      ctrl <= `CTRL_RESET;
      baud <= `BAUD_RESET;
    end else if (wr && paddr_i == `OFS_TX_CTRL) begin
      ctrl <= pwdata_i[6:0];
    end else if (wr && paddr_i == `OFS_TX_BAUD) begin
      baud <= pwdata_i[15:0];
    end
  end
  // Low run length; start, data and break runs are whole bit times
  always @(posedge clk_sys_i) begin
    if (srst_i || serial_tx_o) begin
      low_cnt <= 0;
    end else begin
      low_cnt <= low_cnt + 1;
    end
  end
  ready_high_a: assert property (pready_o) else $error("pready low");
  err_phase_a: assert property (pslverr_o |-> psel_i && penable_i) // none
    else $error("pslverr outside access");
  pin_owner_a: assert property (serial_tx_oe_o == (ctrl[0] | ctrl[1]))
    else $error("pin ownership wrong");
  line_idle_a: assert property (!ctrl[0] |-> serial_tx_o)
    else $error("line low while off");
  irq_gate_a: assert property (irq_mask_i |-> !irq_o)
    else $error("irq through mask");
  low_run_a: assert property ($rose(serial_tx_o) |->
    (low_cnt % (baud + 1)) == 0) else $error("low run not whole bits");
  tick_owner_a: assert property (rx_baud_tick_o |->
    ctrl[1] || $past(ctrl[1])) else $error("tick without rx_go");
  tick_pulse_a: assert property (rx_baud_tick_o |=> !rx_baud_tick_o)
    else $error("tick too long");
  cover property ($rose(serial_tx_o));
  cover property (irq_o);
  cover property (rx_baud_tick_o);
endmodule
bind async_serial_transmitter async_tx_properties async_tx_properties_i (
  .clk_sys_i(clk_sys_i), .srst_i(srst_i), .psel_i(psel_i),
  .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
  .pwdata_i(pwdata_i), .pready_o(pready_o), .pslverr_o(pslverr_o),
  .irq_mask_i(irq_mask_i), .serial_tx_o(serial_tx_o),
  .serial_tx_oe_o(serial_tx_oe_o), .rx_baud_tick_o(rx_baud_tick_o),
  .irq_o(irq_o));
`default_nettype wire

// ---- tb/serial_rx_model.sv ----
// Remote asynchronous receiver watching the serial line.
// Assumes bit time is a whole number of system clocks.
`timescale 1ns/1ps
`default_nettype none
module serial_rx_model #(parameter int BIT_CYCLES = 4) (
  input wire logic clk_sys_i, // Sampling clock
  input wire logic line_i,    // Serial line
  input wire logic nine_i     // Nine-bit words
);
  logic [8:0] word;
  logic [8:0] got_q[$];
  int         breaks = 0;
  // Hunt a start edge, then sample each bit in its middle
  initial begin
    forever begin
      @(negedge line_i);
      repeat (BIT_CYCLES / 2) @(posedge clk_sys_i);
      if (line_i === 1'b0) begin
        word = 0;
        for (int i = 0; i < (nine_i ? 9 : 8); i++) begin
          repeat (BIT_CYCLES) @(posedge clk_sys_i);
          word[i] = line_i;
        end
        repeat (BIT_CYCLES) @(posedge clk_sys_i);
        if (line_i === 1'b1) begin
          got_q.push_back(word);
        end else begin
          breaks++;
          wait (line_i === 1'b1);
        end
      end
    end
  end
endmodule
`default_nettype wire

// ---- tb/async_serial_transmitter_test.sv ----
// Self-checking bench for the serial transmitter.
// Assumes an APB master model here and the receiver model on the line.
`timescale 1ns/1ps
`default_nettype none
`include "async_tx_regs.vh"
module async_serial_transmitter_test;
  localparam int BAUD = 3; // Four clocks per bit
  logic        clk = 0, srst = 1, psel = 0, pen = 0, pwr = 0;
  logic        mask = 0, nine = 0, rerr;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, rdata;
  wire         pready, pslverr, tx, oe, tick, irq;
  wire  [31:0] prdata;
  int          num_errors = 0, total_checks = 0, cyc = 0;
  // Free-running clock
  always #20 clk = ~clk;
  async_serial_transmitter async_serial_transmitter_i (
    .clk_sys_i(clk), .srst_i(srst), .psel_i(psel), .penable_i(pen),
    .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata),
    .pready_o(pready), .prdata_o(prdata), .pslverr_o(pslverr),
    .irq_mask_i(mask), .serial_tx_o(tx), .serial_tx_oe_o(oe),
    .rx_baud_tick_o(tick), .irq_o(irq));
  serial_rx_model #(.BIT_CYCLES(BAUD + 1)) serial_rx_model_i (
    .clk_sys_i(clk), .line_i(tx), .nine_i(nine));
  task test_done;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // Hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      num_errors++;
      test_done();
    end
  end
  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rdata = prdata;
    rerr = pslverr;
    psel <= 0;
    pen <= 0;
  endtask
  task send(input logic [31:0] d);
    apb(0, `OFS_SERIAL_STATUS_REG, 0);
    apb(1, `OFS_SERIAL_DATA_REG, d);
  endtask
  task wait_rx(input int n);
    for (int k = 0; k < 3000 && serial_rx_model_i.got_q.size() < n; k++)
      @(posedge clk);
    repeat (8) @(negedge clk);
  endtask
  function logic [31:0] pop;
    pop = serial_rx_model_i.got_q.pop_front();
  endfunction
  task t_reset;
    apb(0, `OFS_SERIAL_STATUS_REG, 0);
    chk("status", 32'h000000C0, rdata);
    apb(0, `OFS_RX_BAUD, 0);
    chk("rx_baud", 32'h00000032, rdata);
    apb(0, 12'h020, 0);
    chk("bad_err", 1, rerr);
    chk("bad_data", 0, rdata);
    chk("oe_off", 0, oe);
    $display("t_reset done");
  endtask
  task t_idle_first;
    int gap;
    apb(1, `OFS_TX_BAUD, BAUD);
    apb(1, `OFS_TX_CTRL, 1);
    @(negedge clk);
    chk("oe_on", 1, oe);
    send(32'hA5);
    gap = 0;
    while (tx === 1'b1 && gap < 200) begin
      @(negedge clk);
      gap++;
    end
    chk("idle_gap", 1, gap >= 30);
    wait_rx(1);
    chk("word", 32'h0A5, pop());
    $display("t_idle_first done");
  endtask
  task t_direct_b2b;
    logic fell;
    send(32'h5A);
    fell = 0;
    repeat (2) begin
      @(negedge clk);
      if (tx === 1'b0) fell = 1;
    end
    chk("direct_start", 1, fell);
    apb(0, `OFS_SERIAL_STATUS_REG, 0);
    chk("empty_at_once", 32'h80, rdata);
    apb(1, `OFS_SERIAL_DATA_REG, 32'hC3);
    apb(0, `OFS_SERIAL_STATUS_REG, 0);
    chk("held", 32'h00, rdata);
    wait_rx(2);
    chk("word1", 32'h05A, pop());
    chk("word2", 32'h0C3, pop());
    apb(0, `OFS_SERIAL_STATUS_REG, 0);
    chk("drained", 32'hC0, rdata);
    $display("t_direct_b2b done");
  endtask
  task t_nine;
    nine = 1;
    for (int i = 0; i < 2; i++) begin
      apb(1, `OFS_TX_CTRL, i ? 32'h09 : 32'h19);
      send(i ? 32'h1E1 : 32'h0F0);
      wait_rx(1);
      chk("nine", i ? 32'h0E1 : 32'h1F0, pop());
    end
    apb(1, `OFS_TX_CTRL, 1);
    nine = 0;
    $display("t_nine done");
  endtask
  task t_irq;
    apb(1, `OFS_IRQ_CLEAR, 3);
    apb(1, `OFS_IRQ_ENABLE, 2);
    send(32'h11);
    wait_rx(1);
    chk("word", 32'h011, pop());
    chk("irq_done", 1, irq);
    @(posedge clk) mask <= 1;
    @(negedge clk);
    chk("irq_masked", 0, irq);
    @(posedge clk) mask <= 0;
    apb(0, `OFS_IRQ_STATUS, 0);
    chk("done_event", 2, rdata & 2);
    apb(1, `OFS_IRQ_CLEAR, 2);
    apb(0, `OFS_IRQ_STATUS, 0);
    chk("event_clr", 0, rdata & 2);
    chk("irq_clr", 0, irq);
    apb(1, `OFS_IRQ_ENABLE, 0);
    apb(1, `OFS_TX_CTRL, 32'h21);
    @(negedge clk);
    chk("irq_empty", 1, irq);
    apb(1, `OFS_TX_CTRL, 1);
    $display("t_irq done");
  endtask
  task t_break;
    apb(1, `OFS_TX_CTRL, 5);
    repeat (100) @(negedge clk);
    chk("break_low", 0, tx);
    apb(1, `OFS_TX_CTRL, 1);
    send(32'h66);
    wait_rx(1);
    chk("after_break", 32'h066, pop());
    chk("breaks", 1, serial_rx_model_i.breaks);
    $display("t_break done");
  endtask
  task t_rx_tick;
    int n;
    apb(1, `OFS_RX_BAUD, 4);
    apb(1, `OFS_TX_CTRL, 3);
    repeat (10) @(negedge clk);
    n = 0;
    repeat (50) begin
      @(negedge clk);
      if (tick === 1'b1) n++;
    end
    chk("ticks", 10, n);
    apb(1, `OFS_TX_CTRL, 0);
    @(negedge clk);
    chk("released", 0, oe);
    chk("line_off", 1, tx);
    $display("t_rx_tick done");
  endtask
  // Reset, then the scenarios in order
  initial begin
    repeat (6) @(posedge clk);
    srst <= 0;
    t_reset();
    t_idle_first();
    t_direct_b2b();
    t_nine();
    t_irq();
    t_break();
    t_rx_tick();
    test_done();
  end
endmodule
`default_nettype wire
